// ---- maf_pkg.sv ----
package maf_pkg;
  localparam int unsigned MAF_NUM_SLOTS   = 4;       // Default slot count
  localparam int unsigned MAF_OCTETS      = 6;       // Octets per address
  localparam int unsigned MAF_ADDR_W      = 48;      // Address width
  localparam int unsigned MAF_CFG_W       = 8;       // Filter config width
  localparam int unsigned MAF_CFG_EN_BIT  = 0;       // Enable position
  localparam int unsigned MAF_CFG_SRC_BIT = 1;       // Source select position
  localparam int unsigned MAF_CFG_MSK_LSB = 2;       // First octet mask position
  localparam logic [47:0] MAF_ADDR_RST    = 48'h0;   // Address reset value
  localparam logic [7:0]  MAF_CFG_RST     = 8'h00;   // Config reset value
  localparam logic [5:0]  MAF_SER_LAST    = 6'h2f;   // Last serial bit index
endpackage

// ---- maf_store_if.sv ----
`timescale 1ns/1ps
// Slot storage access between filter core and address memory
interface maf_store_if #(parameter int unsigned SLOTS = 4, parameter int unsigned IW = 2);
  logic [IW-1:0] rd_idx;     // Read slot index
  logic [47:0]   rd_addr;    // Registered read data
  logic          wr_en;      // Address write strobe
  logic [IW-1:0] wr_idx;     // Written slot index
  logic [47:0]   wr_addr;    // Written address
  logic [48*SLOTS-1:0] all;  // Every slot, for parallel compare
  modport core (output rd_idx, wr_en, wr_idx, wr_addr, input rd_addr, all);
  modport mem  (input rd_idx, wr_en, wr_idx, wr_addr, output rd_addr, all);
endinterface

// ---- maf_addr_mem.sv ----
`timescale 1ns/1ps
// Address slot memory: only addresses live here, so a write cannot disturb filter settings
module maf_addr_mem
  import maf_pkg::*;
#(
  parameter int unsigned SLOTS = MAF_NUM_SLOTS
) (
  // Clock and reset
  input  wire logic i_clk,
  input  wire logic i_nrst,
  input  wire logic i_ce,
  // Storage port
  maf_store_if.mem  st
);
  logic [47:0] mem_r [SLOTS];  // Address slots, octet 1 in bits 7:0

  // Slot writes, one per cycle
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      for (int i = 0; i < SLOTS; i++) mem_r[i] <= MAF_ADDR_RST;
    end else if (i_ce && st.wr_en) begin
      mem_r[st.wr_idx] <= st.wr_addr;
    end
  end

  // Registered read port
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      st.rd_addr <= MAF_ADDR_RST;
    end else if (i_ce) begin
      st.rd_addr <= mem_r[st.rd_idx];
    end
  end

  // Flat view for the comparators
  for (genvar g = 0; g < SLOTS; g++) begin : g_flat
    assign st.all[48*g +: 48] = mem_r[g];
  end
endmodule

// ---- maf_filter.sv ----
`timescale 1ns/1ps
// Station address slots, perfect filter and transmit source address serialiser
module maf_filter
  import maf_pkg::*;
#(
  parameter int unsigned SLOTS = MAF_NUM_SLOTS,
  parameter int unsigned IW    = $clog2(SLOTS)
) (
  // Clock, reset, enable
  input  wire logic          i_clk,
  input  wire logic          i_nrst,
  input  wire logic          i_ce,
  // Address write and read
  input  wire logic          i_addr_wr,
  input  wire logic [IW-1:0] i_addr_idx,
  input  wire logic [47:0]   i_addr_data,
  output logic [47:0]        o_addr_rdata,
  // Filter settings write and read
  input  wire logic          i_cfg_wr,
  input  wire logic [IW-1:0] i_cfg_idx,
  input  wire logic [7:0]    i_cfg_data,
  output logic [7:0]         o_cfg_rdata,
  output logic [IW:0]        o_num_slots,
  // Mode controls
  input  wire logic          i_promisc,
  input  wire logic          i_hash_mode,
  input  wire logic          i_hash_hit,
  // Received frame addresses
  input  wire logic          i_rx_valid,
  input  wire logic [47:0]   i_rx_dst,
  input  wire logic [47:0]   i_rx_src,
  output logic               o_rx_done,
  output logic               o_rx_accept,
  // Transmit source address insertion
  input  wire logic          i_tx_start,
  input  wire logic          i_tx_adv,
  output logic               o_tx_bit,
  output logic               o_tx_busy
);
  maf_store_if #(.SLOTS(SLOTS), .IW(IW)) st ();

  logic [7:0]  cfg_r [SLOTS];   // Per-slot settings, slot 0 unused
  logic [SLOTS-1:0] hit;        // Per-slot match
  logic [47:0] tx_sh_r;         // Serial source address
  logic [5:0]  tx_cnt_r;        // Bit index
  logic        rx_accept_nxt;   // Filter decision
  logic [6:0]  tx_seen_r;       // Advances per insertion, checks only

  maf_addr_mem #(.SLOTS(SLOTS)) u_mem (
    .i_clk  (i_clk),
    .i_nrst (i_nrst),
    .i_ce   (i_ce),
    .st     (st)
  );

  // Address writes touch only the memory, never cfg_r
  assign st.wr_en   = i_addr_wr;
  assign st.wr_idx  = i_addr_idx;
  assign st.wr_addr = i_addr_data;
  assign st.rd_idx  = i_addr_idx;
  assign o_addr_rdata = st.rd_addr;

  // Settings writes; slot 0 and out-of-range indices are ignored
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      for (int i = 0; i < SLOTS; i++) cfg_r[i] <= MAF_CFG_RST;
    end else if (i_ce && i_cfg_wr && i_cfg_idx != '0 && 32'(i_cfg_idx) < SLOTS) begin
      cfg_r[i_cfg_idx] <= i_cfg_data;
    end
  end

  // Settings readback and slot count
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_cfg_rdata <= MAF_CFG_RST;
      o_num_slots <= '0;
    end else if (i_ce) begin
      o_cfg_rdata <= (i_cfg_idx == '0) ? MAF_CFG_RST : cfg_r[i_cfg_idx];
      o_num_slots <= (IW+1)'(SLOTS);
    end
  end

  // Per-slot masked compare; slot 0 is always a destination compare
  for (genvar s = 0; s < SLOTS; s++) begin : g_slot
    logic [47:0] ref_a;
    logic [5:0]  oct_ok;
    assign ref_a = (s != 0 && cfg_r[s][MAF_CFG_SRC_BIT]) ? i_rx_src : i_rx_dst;
    for (genvar o = 0; o < MAF_OCTETS; o++) begin : g_oct
      // Octet 1 sits in bits 7:0, mask bit 2 ignores it
      assign oct_ok[o] = (s != 0 && cfg_r[s][MAF_CFG_MSK_LSB+o])
                       || (ref_a[8*o +: 8] == st.all[48*s + 8*o +: 8]);
    end
    if (s == 0) begin : g_local
      assign hit[s] = &oct_ok;
    end else begin : g_filt
      assign hit[s] = cfg_r[s][MAF_CFG_EN_BIT] && (&oct_ok);
      // Whole-address check of an enabled slot with no octet ignored, taken straight from its settings
      a_slot_match: assert property (@(posedge i_clk) disable iff (!i_nrst)
        (i_ce && i_rx_valid && !i_promisc && !i_hash_mode
         && cfg_r[s][MAF_CFG_EN_BIT] && (cfg_r[s][MAF_CFG_MSK_LSB +: 6] == 6'h00)
         && ((cfg_r[s][MAF_CFG_SRC_BIT] ? i_rx_src : i_rx_dst) == st.all[48*s +: 48])) |=> o_rx_accept)
        else $error("enabled slot match rejected");
    end
  end

  // Decision: promiscuous passes all, hash mode bypasses slot settings
  // Local match stays live in hash mode, so own traffic never hangs on the hash table
  always_comb begin
    if (i_promisc) begin
      rx_accept_nxt = 1'b1;
    end else if (i_hash_mode) begin
      rx_accept_nxt = hit[0] || i_hash_hit;
    end else begin
      rx_accept_nxt = |hit;
    end
  end

  // Registered verdict, one cycle after the addresses are offered
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_rx_done   <= 1'b0;
      o_rx_accept <= 1'b0;
    end else if (i_ce) begin
      o_rx_done   <= i_rx_valid;
      o_rx_accept <= i_rx_valid && rx_accept_nxt;
    end
  end

  // Source address serialiser: octet 1 first, LSB first within each octet
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      tx_sh_r   <= MAF_ADDR_RST;
      tx_cnt_r  <= '0;
      o_tx_busy <= 1'b0;
      o_tx_bit  <= 1'b0;
    end else if (i_ce) begin
      if (i_tx_start && !o_tx_busy) begin
        tx_sh_r   <= {1'b0, st.all[47:1]};
        o_tx_bit  <= st.all[0];
        tx_cnt_r  <= '0;
        o_tx_busy <= 1'b1;
      end else if (o_tx_busy && i_tx_adv) begin
        if (tx_cnt_r == MAF_SER_LAST) begin
          o_tx_busy <= 1'b0;
          o_tx_bit  <= 1'b0;
        end else begin
          o_tx_bit <= tx_sh_r[0];
          tx_sh_r  <= {1'b0, tx_sh_r[47:1]};
          tx_cnt_r <= tx_cnt_r + 6'h01;
        end
      end
    end
  end

  // Shadow count of advances per insertion; kept apart from tx_cnt_r so the length check
  // does not merely restate the serialiser's own end test
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      tx_seen_r <= 7'h00;
    end else if (i_ce) begin
      if (i_tx_start && !o_tx_busy) begin
        tx_seen_r <= 7'h00;  // New insertion
      end else if (o_tx_busy && i_tx_adv) begin
        tx_seen_r <= tx_seen_r + 7'h01;  // One more advance taken
      end
    end
  end

  // Promiscuous frames always pass
  a_promisc_accept: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (i_ce && i_rx_valid && i_promisc) |=> o_rx_accept)
    else $error("promiscuous frame rejected");
  // Nothing matched in perfect mode, so nothing may pass
  a_disabled_slot: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (i_ce && i_rx_valid && !i_promisc && !i_hash_mode && !hit[0] && (hit[SLOTS-1:1] == '0))
    |=> !o_rx_accept) else $error("frame accepted without a match");
  // Own station address is accepted in every mode
  a_local_accept: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (i_ce && i_rx_valid && i_rx_dst == st.all[47:0]) |=> o_rx_accept)
    else $error("local address rejected");
  // Slot 0 never picks up settings
  a_slot0_cfg: assert property (@(posedge i_clk) disable iff (!i_nrst)
    cfg_r[0] == MAF_CFG_RST)
    else $error("slot 0 has settings");
  // Slot 0 reads back as having no settings
  a_cfg_zero: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (i_ce && i_cfg_idx == '0) |=> (o_cfg_rdata == MAF_CFG_RST))
    else $error("slot 0 settings read back");
  // An address write leaves the settings of the last slot (SLOTS-1) alone
  a_cfg_keep: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (i_addr_wr && !i_cfg_wr) |=> $stable(cfg_r[SLOTS-1]))
    else $error("address write changed settings");
  // Read port returns the slot as stored, octet order kept
  a_addr_readback: assert property (@(posedge i_clk) disable iff (!i_nrst)
    i_ce |=> (o_addr_rdata == $past(st.all[48*i_addr_idx +: 48])))
    else $error("address readback wrong");
  // First bit out is bit 0 of the local address
  a_tx_first_bit: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (i_ce && i_tx_start && !o_tx_busy && !i_addr_wr) |=> (o_tx_bit == $past(st.all[0]) && o_tx_busy))
    else $error("wrong first source bit");
  // Busy drops on the advance after the last bit
  a_tx_length: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (o_tx_busy && i_ce && i_tx_adv && tx_cnt_r == MAF_SER_LAST) |=> !o_tx_busy)
    else $error("serialiser overran");
  // Every insertion takes one advance per address bit, no more and no less
  a_tx_bit_count: assert property (@(posedge i_clk) disable iff (!i_nrst)
    $fell(o_tx_busy) |-> (tx_seen_r == 7'(MAF_OCTETS * 8)))
    else $error("insertion bit count wrong");
  // Hash mode ignores the slot settings
  a_hash_bypass: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (i_ce && i_rx_valid && !i_promisc && i_hash_mode && !i_hash_hit && !hit[0]) |=> !o_rx_accept)
    else $error("slot settings used in hash mode");
  // Every offered frame gets a verdict strobe
  a_verdict_strobe: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (i_ce && i_rx_valid) |=> o_rx_done)
    else $error("verdict strobe missing");
  // An accept never stands without its strobe
  a_accept_framed: assert property (@(posedge i_clk) disable iff (!i_nrst)
    o_rx_accept |-> o_rx_done)
    else $error("accept without strobe");
  // Slot count is published once running
  a_num_slots: assert property (@(posedge i_clk) disable iff (!i_nrst)
    $past(i_ce) |-> o_num_slots == (IW+1)'(SLOTS))
    else $error("slot count wrong");
endmodule

// ---- maf_phy_model.sv ----
`timescale 1ns/1ps
// Link-side receiver: strobes the source serialiser and gathers its bits
module maf_phy_model (
  // Clock and reset
  input  wire logic   i_clk,
  input  wire logic   i_nrst,
  // Pace select from bench
  input  wire logic   i_slow,
  // Serialiser side
  input  wire logic   i_tx_bit,
  input  wire logic   i_tx_busy,
  output logic        o_tx_adv,
  output logic [47:0] o_cap
);
  // Strobe each cycle, or every other one to stall like a slow link
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_tx_adv <= 1'b0;
    end else begin
      o_tx_adv <= i_slow ? ~o_tx_adv : 1'b1;
    end
  end
  // First bit lands lowest after 48 shifts, LSB-first per octet
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_cap <= 48'h0;
    end else if (i_tx_busy && o_tx_adv) begin
      o_cap <= {i_tx_bit, o_cap[47:1]};
    end
  end
endmodule

// ---- test_mac_address_perfect_filter.sv ----
`timescale 1ns/1ps
// Bench for address slots, perfect filter and source serialiser
module test_mac_address_perfect_filter;
  import maf_pkg::*;
  logic        clk, nrst, ce, awr, cwr, promisc, hmode, hhit, rxv, txs, slow; // Bench controls
  logic [1:0]  aidx, cidx;                                                     // Slot indices
  logic [7:0]  cdata, crdata;                                                  // Settings
  logic [47:0] adata, ardata, dst, src, cap;                                   // Addresses
  logic [2:0]  nslots;                                                         // Slot count
  logic        done, acc, adv, tbit, busy;                                     // Returned flags
  int          miscompares, n_checks;                                          // Tallies
  logic [47:0] a [4];                                                          // Slot contents
  logic [47:0] o;                                                              // Unknown station
  maf_filter #(.SLOTS(4)) dut_u (.i_clk(clk), .i_nrst(nrst), .i_ce(ce), .i_addr_wr(awr), .i_addr_idx(aidx),
    .i_addr_data(adata), .o_addr_rdata(ardata), .i_cfg_wr(cwr), .i_cfg_idx(cidx), .i_cfg_data(cdata),
    .o_cfg_rdata(crdata), .o_num_slots(nslots), .i_promisc(promisc), .i_hash_mode(hmode), .i_hash_hit(hhit),
    .i_rx_valid(rxv), .i_rx_dst(dst), .i_rx_src(src), .o_rx_done(done), .o_rx_accept(acc), .i_tx_start(txs),
    .i_tx_adv(adv), .o_tx_bit(tbit), .o_tx_busy(busy));
  maf_phy_model phy_u (.i_clk(clk), .i_nrst(nrst), .i_slow(slow), .i_tx_bit(tbit), .i_tx_busy(busy),
    .o_tx_adv(adv), .o_cap(cap));
  // 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Compare and tally
  task automatic chk(input string nm, input logic [47:0] seen, input logic [47:0] exp);
    n_checks++;
    if (seen !== exp) begin
      $display("Error %s expected %h seen %h", nm, exp, seen);
      miscompares++;
    end
  endtask
  // Counts, verdict, end
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // One-cycle write: settings when c is set, else address
  task automatic wr(input logic c, input logic [1:0] i, input logic [47:0] d);
    @(posedge clk);
    cwr <= c;
    awr <= ~c;
    cidx <= i;
    aidx <= i;
    cdata <= d[7:0];
    adata <= d;
    @(posedge clk);
    awr <= 1'b0;
    cwr <= 1'b0;
  endtask
  // Readback is registered, so compare one cycle after the index
  task automatic rd(input logic [1:0] i, input logic [47:0] ea, input logic [7:0] ec);
    @(posedge clk);
    aidx <= i;
    cidx <= i;
    @(posedge clk);
    #1;
    chk("addr", ardata, ea);
    chk("cfg", crdata, {40'h0, ec});
  endtask
  // One frame; verdict stands one cycle later
  task automatic frame(input logic [47:0] d, input logic [47:0] s, input logic e);
    @(posedge clk);
    rxv <= 1'b1;
    dst <= d;
    src <= s;
    @(posedge clk);
    rxv <= 1'b0;
    #1;
    chk("done", {47'h0, done}, 48'h1);
    chk("accept", {47'h0, acc}, {47'h0, e});
  endtask
  // Source insertion, bounded wait for busy to drop
  task automatic send(input logic s);
    @(posedge clk);
    slow <= s;
    txs <= 1'b1;
    @(posedge clk);
    txs <= 1'b0;
    #1;
    chk("txbusy", {47'h0, busy}, 48'h1);
    chk("txfirst", {47'h0, tbit}, {47'h0, a[0][0]});
    for (int k = 0; k < 200 && busy !== 1'b0; k++) begin
      @(posedge clk);
      #1;
    end
    chk("txidle", {47'h0, busy}, 48'h0);
    chk("txaddr", cap, a[0]);
  endtask
  // Hang guard, far beyond the few hundred cycles expected
  initial begin
    repeat (5000) @(posedge clk);
    miscompares++;
    complete_run();
  end
  initial begin
    {nrst, ce, awr, cwr, promisc, hmode, hhit, rxv, txs, slow} = '0;
    {aidx, cidx, cdata, adata, dst, src} = '0;
    miscompares = 0;
    n_checks = 0;
    o = 48'h777777777777;
    a = '{48'h0a0b0c0d0e02, 48'h665544332211, 48'h1234567890ab, 48'h0f0e0d0c0b0a};
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    ce <= 1'b1;
    rd(2'd0, 48'h0, 8'h00);
    chk("slots", {45'h0, nslots}, 48'h4);
    for (int i = 0; i < 4; i++) wr(1'b0, i[1:0], a[i]);
    wr(1'b1, 2'd0, 48'hff);
    wr(1'b1, 2'd1, 48'h01);
    wr(1'b1, 2'd2, 48'h03);
    wr(1'b1, 2'd3, 48'hfc);
    wr(1'b0, 2'd2, a[2]);
    rd(2'd0, a[0], 8'h00);
    rd(2'd2, a[2], 8'h03);
    rd(2'd3, a[3], 8'hfc);
    @(posedge clk);
    ce <= 1'b0;
    wr(1'b0, 2'd1, o);
    ce <= 1'b1;
    rd(2'd1, a[1], 8'h01);
    $display("test registers done");
    frame(a[0], o, 1'b1);
    frame(a[1], o, 1'b1);
    frame(o, a[1], 1'b0);
    frame(o, a[2], 1'b1);
    frame(o, o, 1'b0);
    for (int k = 0; k < 6; k++) begin
      wr(1'b1, 2'd1, {40'h0, 8'h01 | (8'h04 << k)});
      frame(a[1] ^ (48'h5a << (8 * k)), o, 1'b1);
      frame(a[1] ^ (48'h5a << (8 * ((k + 1) % 6))), o, 1'b0);
    end
    @(posedge clk);
    promisc <= 1'b1;
    frame(o, o, 1'b1);
    @(posedge clk);
    promisc <= 1'b0;
    hmode <= 1'b1;
    frame(a[1], o, 1'b0);
    frame(a[0], o, 1'b1);
    @(posedge clk);
    hhit <= 1'b1;
    frame(o, o, 1'b1);
    @(posedge clk);
    hmode <= 1'b0;
    $display("test filter done");
    send(1'b0);
    send(1'b1);
    $display("test transmit done");
    complete_run();
  end
endmodule
